// ### core/gxp_top.sv
// gpio expander: serial target on link_clk, port pins and change alert on core_clk
`timescale 1ns/1ps
`include "gxp_cfg.svh"

module gxp_top #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             link_clk,
  input  wire logic             reset_pin_n,
  input  wire logic             addr_sel,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  input  wire logic [WIDTH-1:0] port_pins_i,
  output logic      [WIDTH-1:0] port_pins_o,
  output logic      [WIDTH-1:0] port_pins_oe,
  output logic                  alert_n_o,
  output logic                  alert_n_oe
);

  if (WIDTH != 8) begin : g_check
    $error("gxp_top serves exactly one byte of port pins");
  end

  // reset pin and system reset both reset everything
  logic arst;
  assign arst = rst | ~reset_pin_n;

  logic crst_s1, crst, lrst_s1, lrst;
  always_ff @(posedge core_clk or posedge arst) begin
    if (arst) begin
      crst_s1 <= 1'h1;
      crst    <= 1'h1;
    end else begin
      crst_s1 <= 1'h0;
      crst    <= crst_s1;
    end
  end

  always_ff @(posedge link_clk or posedge arst) begin
    if (arst) begin
      lrst_s1 <= 1'h1;
      lrst    <= 1'h1;
    end else begin
      lrst_s1 <= 1'h0;
      lrst    <= lrst_s1;
    end
  end

  // ---------------- link domain ----------------
  logic ce_s1, ce_l, scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic addr_s1, addr_s2;
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      {ce_s1, ce_l} <= 2'h0;
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {addr_s1, addr_s2} <= 2'h0;
    end else begin
      ce_s1 <= ce;
      ce_l  <= ce_s1;
      if (ce_l) begin
        {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
        {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
        {addr_s1, addr_s2} <= {addr_sel, addr_s1};
      end
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = ce_l & scl_s2 & ~scl_s3;
  assign scl_fall = ce_l & ~scl_s2 & scl_s3;
  assign start_c  = ce_l & scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_c   = ce_l & scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  gxp_pkg::gxp_state_t st_r;
  gxp_pkg::gxp_cfg_t   lreg_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r, in_copy_r;
  logic [1:0] ptr_r;
  logic       rw_r, mack_r, sda_oe_r;

  // register read mux, shared by first and following read bytes
  function automatic logic [7:0] rd_sel(input logic [1:0] p, input gxp_pkg::gxp_cfg_t r,
                                        input logic [7:0] smp);
    case (p)
      `GXP_REG_INPUT:  rd_sel = smp ^ r.inv;
      `GXP_REG_OUTPUT: rd_sel = r.out;
      `GXP_REG_INVERT: rd_sel = r.inv;
      default:         rd_sel = r.dir;
    endcase
  endfunction

  logic [7:0] rd_byte;
  logic       load_now, wr_now, addr_hit;
  assign rd_byte  = rd_sel(ptr_r, lreg_r, in_copy_r);
  assign load_now = scl_fall & ((st_r == gxp_pkg::GXP_AACK & rw_r) |
                                (st_r == gxp_pkg::GXP_RACK & mack_r));
  assign wr_now   = scl_fall & st_r == gxp_pkg::GXP_WDATA & cnt_r == `GXP_BYTE_END;
  assign addr_hit = sh_r[7:1] == {`GXP_ADDR_BASE, addr_s2};

  // serial state machine; sda_oe high pulls the line low
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      st_r     <= gxp_pkg::GXP_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      ptr_r    <= 2'h0;
      rw_r     <= 1'h0;
      mack_r   <= 1'h0;
      sda_oe_r <= 1'h0;
    end else if (start_c) begin
      st_r     <= gxp_pkg::GXP_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'h0;
    end else if (stop_c) begin
      st_r     <= gxp_pkg::GXP_IDLE;
      sda_oe_r <= 1'h0;
    end else if (scl_rise) begin
      case (st_r)
        gxp_pkg::GXP_ADDR, gxp_pkg::GXP_PTR, gxp_pkg::GXP_WDATA: begin
          sh_r  <= {sh_r[6:0], sda_s2};
          cnt_r <= cnt_r + 4'h1;
        end
        gxp_pkg::GXP_RDATA: cnt_r <= cnt_r + 4'h1;
        gxp_pkg::GXP_RACK:  mack_r <= ~sda_s2;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_r)
        gxp_pkg::GXP_ADDR: begin
          if (cnt_r == `GXP_BYTE_END) begin
            if (addr_hit) begin
              sda_oe_r <= 1'h1;
              rw_r     <= sh_r[0];
              st_r     <= gxp_pkg::GXP_AACK;
            end else begin
              st_r <= gxp_pkg::GXP_IDLE;
            end
          end
        end
        gxp_pkg::GXP_PTR: begin
          if (cnt_r == `GXP_BYTE_END) begin
            if (sh_r[7:2] == 6'h00) begin
              ptr_r    <= sh_r[1:0];
              sda_oe_r <= 1'h1;
              st_r     <= gxp_pkg::GXP_PACK;
            end else begin
              st_r <= gxp_pkg::GXP_IDLE;
            end
          end
        end
        gxp_pkg::GXP_WDATA: begin
          if (cnt_r == `GXP_BYTE_END) begin
            sda_oe_r <= 1'h1;
            st_r     <= gxp_pkg::GXP_WACK;
          end
        end
        gxp_pkg::GXP_AACK, gxp_pkg::GXP_RACK: begin
          cnt_r <= 4'h0;
          if (load_now) begin
            sda_oe_r <= ~rd_byte[7];
            tx_r     <= {rd_byte[6:0], 1'h0};
            st_r     <= gxp_pkg::GXP_RDATA;
          end else begin
            sda_oe_r <= 1'h0;
            st_r     <= st_r == gxp_pkg::GXP_AACK ? gxp_pkg::GXP_PTR : gxp_pkg::GXP_IDLE;
          end
        end
        gxp_pkg::GXP_PACK, gxp_pkg::GXP_WACK: begin
          sda_oe_r <= 1'h0;
          cnt_r    <= 4'h0;
          st_r     <= gxp_pkg::GXP_WDATA;
        end
        gxp_pkg::GXP_RDATA: begin
          if (cnt_r == `GXP_BYTE_END) begin
            sda_oe_r <= 1'h0;
            st_r     <= gxp_pkg::GXP_RACK;
          end else begin
            sda_oe_r <= ~tx_r[7];
            tx_r     <= {tx_r[6:0], 1'h0};
          end
        end
        default: st_r <= gxp_pkg::GXP_IDLE;
      endcase
    end
  end

  // writable registers; the input register is read only
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      lreg_r.dir <= `GXP_DIR_RST;
      lreg_r.out <= `GXP_OUT_RST;
      lreg_r.inv <= `GXP_INV_RST;
    end else if (wr_now) begin
      case (ptr_r)
        `GXP_REG_OUTPUT: lreg_r.out <= sh_r;
        `GXP_REG_INVERT: lreg_r.inv <= sh_r;
        `GXP_REG_DIR:    lreg_r.dir <= sh_r;
        default: ;
      endcase
    end
  end

  // config word to core: held word plus toggle request, echoed back
  gxp_pkg::gxp_cfg_t cfg_hold_r, cfg_c_r;
  logic cfg_req_r, cfg_pend_r, cack_s1, cack_s2, cfg_ack_r;
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      cfg_hold_r <= {`GXP_DIR_RST, `GXP_OUT_RST, `GXP_INV_RST};
      cfg_req_r  <= 1'h0;
      cfg_pend_r <= 1'h0;
      {cack_s1, cack_s2} <= 2'h0;
    end else if (ce_l) begin
      {cack_s1, cack_s2} <= {cfg_ack_r, cack_s1};
      if (cfg_pend_r && cfg_req_r == cack_s2) begin
        cfg_hold_r <= lreg_r;
        cfg_req_r  <= ~cfg_req_r;
        cfg_pend_r <= wr_now;
      end else if (wr_now) begin
        cfg_pend_r <= 1'h1;
      end
    end
  end

  // pin samples from core, and input-read event back to core
  logic [7:0] smp_hold_r, rd_val_r;
  logic sreq_r, sreq_s1, sreq_s2, sreq_s3, sack_r, rd_tgl_r;
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      {sreq_s1, sreq_s2, sreq_s3} <= 3'h0;
      sack_r    <= 1'h0;
      in_copy_r <= 8'h00;
      rd_val_r  <= 8'h00;
      rd_tgl_r  <= 1'h0;
    end else if (ce_l) begin
      {sreq_s1, sreq_s2, sreq_s3} <= {sreq_r, sreq_s1, sreq_s2};
      if (sreq_s2 != sreq_s3) begin
        in_copy_r <= smp_hold_r;
        sack_r    <= sreq_s2;
      end
      if (load_now && ptr_r == `GXP_REG_INPUT) begin
        rd_val_r <= in_copy_r;
      end
      if (scl_rise && st_r == gxp_pkg::GXP_RACK && ptr_r == `GXP_REG_INPUT) begin
        rd_tgl_r <= ~rd_tgl_r;
      end
    end
  end

  // ---------------- core domain ----------------
  logic [7:0] pin_s1, pin_s2, capt_r;
  logic creq_s1, creq_s2, creq_s3, sack_s1, sack_s2, rd_s1, rd_s2, rd_s3;
  logic [1:0] init_r;
  always_ff @(posedge core_clk or posedge crst) begin
    if (crst) begin
      {pin_s1, pin_s2} <= 16'h0000;
      {creq_s1, creq_s2, creq_s3} <= 3'h0;
      {sack_s1, sack_s2, rd_s1, rd_s2, rd_s3} <= 5'h00;
    end else if (ce) begin
      {pin_s1, pin_s2} <= {port_pins_i, pin_s1};
      {creq_s1, creq_s2, creq_s3} <= {cfg_req_r, creq_s1, creq_s2};
      {sack_s1, sack_s2} <= {sack_r, sack_s1};
      {rd_s1, rd_s2, rd_s3} <= {rd_tgl_r, rd_s1, rd_s2};
    end
  end

  // config copy, sample publishing
  always_ff @(posedge core_clk or posedge crst) begin
    if (crst) begin
      cfg_c_r    <= {`GXP_DIR_RST, `GXP_OUT_RST, `GXP_INV_RST};
      cfg_ack_r  <= 1'h0;
      smp_hold_r <= 8'h00;
      sreq_r     <= 1'h0;
    end else if (ce) begin
      if (creq_s2 != creq_s3) begin
        cfg_c_r   <= cfg_hold_r;
        cfg_ack_r <= creq_s2;
      end
      if (sreq_r == sack_s2) begin
        smp_hold_r <= pin_s2;
        sreq_r     <= ~sreq_r;
      end
    end
  end

  // captured levels and alert
  logic [7:0] diff_c;
  assign diff_c = (pin_s2 ^ capt_r) & cfg_c_r.dir;
  logic alert_oe_r;
  always_ff @(posedge core_clk or posedge crst) begin
    if (crst) begin
      init_r     <= `GXP_INIT_CYC;
      capt_r     <= 8'h00;
      alert_oe_r <= 1'h0;
    end else if (ce) begin
      if (init_r != 2'h0) begin
        init_r <= init_r - 2'h1;
        capt_r <= pin_s2;
      end else if (rd_s2 != rd_s3) begin
        capt_r <= rd_val_r;
      end
      alert_oe_r <= init_r == 2'h0 && diff_c != 8'h00;
    end
  end

  // port pin drivers
  logic [7:0] pin_o_r, pin_oe_r;
  logic       low_r;
  always_ff @(posedge core_clk or posedge crst) begin
    if (crst) begin
      pin_o_r  <= `GXP_OUT_RST;
      pin_oe_r <= 8'h00;
      low_r    <= 1'h0;
    end else if (ce) begin
      pin_o_r  <= cfg_c_r.out;
      pin_oe_r <= ~cfg_c_r.dir;
    end
  end

  assign port_pins_o  = pin_o_r;
  assign port_pins_oe = pin_oe_r;
  assign alert_n_o    = low_r;
  assign alert_n_oe   = alert_oe_r;
  assign sda_o        = low_r;
  assign sda_oe       = sda_oe_r;

  // checks, core domain
  a_pin_enable: assert property (@(posedge core_clk) disable iff (crst)
    ce |=> pin_oe_r == ~$past(cfg_c_r.dir)) else $error("pin enable not from direction");
  a_pin_value: assert property (@(posedge core_clk) disable iff (crst)
    ce |=> pin_o_r == $past(cfg_c_r.out)) else $error("pin value not from output register");
  a_alert_cause: assert property (@(posedge core_clk) disable iff (crst)
    ce && init_r == 2'h0 && diff_c != 8'h00 |=> alert_oe_r) else $error("alert missed");
  a_alert_quiet: assert property (@(posedge core_clk) disable iff (crst)
    ce && diff_c == 8'h00 |=> !alert_oe_r) else $error("alert without input change");
  a_read_capture: assert property (@(posedge core_clk) disable iff (crst)
    ce && init_r == 2'h0 && rd_s2 != rd_s3 |=> capt_r == $past(rd_val_r))
    else $error("input read did not recapture");
  // checks, link domain, and the alert cover on core clock
  a_addr_ack: assert property (@(posedge link_clk) disable iff (lrst)
    scl_fall && st_r == gxp_pkg::GXP_ADDR && cnt_r == `GXP_BYTE_END && addr_hit
    |=> sda_oe_r && st_r == gxp_pkg::GXP_AACK) else $error("own address not acked");
  a_foreign_addr: assert property (@(posedge link_clk) disable iff (lrst)
    scl_fall && st_r == gxp_pkg::GXP_ADDR && cnt_r == `GXP_BYTE_END && !addr_hit
    |=> !sda_oe_r && st_r == gxp_pkg::GXP_IDLE) else $error("foreign address answered");
  a_invert_read: assert property (@(posedge link_clk) disable iff (lrst)
    load_now && ptr_r == `GXP_REG_INPUT
    |=> sda_oe_r == ~($past(in_copy_r[7]) ^ $past(lreg_r.inv[7])))
    else $error("input bit not inverted by mask");
  a_reg_readback: assert property (@(posedge link_clk) disable iff (lrst)
    load_now && ptr_r == `GXP_REG_OUTPUT |=> tx_r == {$past(lreg_r.out[6:0]), 1'h0})
    else $error("output register read back wrong");
  a_stop_idle: assert property (@(posedge link_clk) disable iff (lrst)
    stop_c && !start_c |=> st_r == gxp_pkg::GXP_IDLE && !sda_oe_r) else $error("stop ignored");
  c_input_read: cover property (@(posedge link_clk) disable iff (lrst)
    scl_rise && st_r == gxp_pkg::GXP_RACK && ptr_r == `GXP_REG_INPUT);
  c_reg_write: cover property (@(posedge link_clk) disable iff (lrst) wr_now);
  c_alert_rise: cover property (@(posedge core_clk) disable iff (crst) $rose(alert_oe_r));

endmodule

// ### core/gxp_cfg.svh
// register indices, reset values and address constants of the gpio expander
`ifndef GXP_CFG_SVH
`define GXP_CFG_SVH
`define GXP_REG_INPUT  2'h0
`define GXP_REG_OUTPUT 2'h1
`define GXP_REG_INVERT 2'h2
`define GXP_REG_DIR    2'h3
`define GXP_DIR_RST    8'hff
`define GXP_OUT_RST    8'h00
`define GXP_INV_RST    8'h00
`define GXP_ADDR_BASE  6'h10
`define GXP_INIT_CYC   2'h3
`define GXP_BYTE_END   4'h8
`endif

// ### core/gxp_pkg.sv
// shared types of the gpio expander
package gxp_pkg;
  typedef enum logic [3:0] {
    GXP_IDLE, GXP_ADDR, GXP_AACK, GXP_PTR, GXP_PACK,
    GXP_WDATA, GXP_WACK, GXP_RDATA, GXP_RACK
  } gxp_state_t;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
    logic [7:0] inv;
  } gxp_cfg_t;
endpackage

// ### sim/gxp_i2c_ctrl.sv
// serial bus controller model driving the expander's target port
`timescale 1ns/1ps
module gxp_i2c_ctrl #(
  parameter int PH = 5
) (
  input  wire logic link_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // idle bus: both lines released to their pull-ups
  initial begin
    scl     = 1'h1;
    sda_low = 1'h0;
  end

  // step just after a link clock edge
  task automatic wt(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask

  // start or repeated start, leaves scl low
  task automatic start();
    wt(2);
    sda_low = 1'h0;
    wt(PH);
    scl = 1'h1;
    wt(PH);
    sda_low = 1'h1;
    wt(PH);
    scl = 1'h0;
  endtask

  // stop condition, leaves the bus idle
  task automatic stop();
    wt(2);
    sda_low = 1'h1;
    wt(PH);
    scl = 1'h1;
    wt(PH);
    sda_low = 1'h0;
    wt(PH);
  endtask

  // one bit: data set while scl low, line sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_low = ~b;
    wt(PH);
    scl = 1'h1;
    wt(PH);
    r   = sda;
    scl = 1'h0;
  endtask

  // byte out msb first, then the target's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'h1, r);
    ack = ~r;
  endtask

  // byte in msb first, then our ack or nack
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

// ### sim/tb.sv
// self-checking bench of the gpio expander with a serial controller model
`timescale 1ns/1ps
`include "gxp_cfg.svh"
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); \
  end \
end
module tb;
  logic       core_clk    = 1'h0;
  logic       link_clk    = 1'h0;
  logic       rst         = 1'h1;
  logic       reset_pin_n = 1'h1;
  logic       addr_sel    = 1'h0;
  logic       ce          = 1'h1;
  logic [7:0] ext         = 8'h5a;
  logic [7:0] pins_o;
  logic [7:0] pins_oe;
  logic [7:0] pins_i;
  logic       sda_o;
  logic       sda_oe;
  logic       alert_n_o;
  logic       alert_n_oe;
  logic       scl;
  logic       m_low;
  logic       sda;
  logic       ack;
  logic [7:0] rd;
  int         error_cnt   = 0;
  int         n_tests     = 0;
  int         cyc         = 0;

  // core clock and an unrelated link clock
  always #2.5 core_clk = ~core_clk;
  initial begin
    #3.7;
    forever begin
      link_clk = ~link_clk; // first rise lands inside the start-up reset
      #16;
    end
  end

  // wired-and bus line and pin levels seen by the device
  assign sda    = ~(m_low | (sda_oe & ~sda_o));
  assign pins_i = (pins_oe & pins_o) | (~pins_oe & ext);

  gxp_top uut (
    .core_clk(core_clk), .rst(rst), .ce(ce), .link_clk(link_clk),
    .reset_pin_n(reset_pin_n), .addr_sel(addr_sel), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .port_pins_i(pins_i), .port_pins_o(pins_o),
    .port_pins_oe(pins_oe), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe)
  );

  gxp_i2c_ctrl m (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_low(m_low));

  task automatic st(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // drive the external pin levels, then let sync and alert settle
  task automatic pin(input logic [7:0] v);
    st(1);
    ext = v;
    st(40);
  endtask

  // register write: address, pointer, data
  task automatic wr(input logic [1:0] p, input logic [7:0] v);
    m.start();
    m.wbyte({`GXP_ADDR_BASE, addr_sel, 1'h0}, ack);
    `CHK(ack, 1'h1)
    m.wbyte({6'h00, p}, ack);
    m.wbyte(v, ack);
    `CHK(ack, 1'h1)
    m.stop();
    st(40);
  endtask

  // register read: set pointer, repeated start, one byte then nack
  task automatic rdr(input logic [1:0] p, input logic [7:0] e);
    m.start();
    m.wbyte({`GXP_ADDR_BASE, addr_sel, 1'h0}, ack);
    m.wbyte({6'h00, p}, ack);
    m.start();
    m.wbyte({`GXP_ADDR_BASE, addr_sel, 1'h1}, ack);
    m.rbyte(1'h1, rd);
    m.stop();
    `CHK(rd, e)
    st(40);
  endtask

  task automatic t_reset();
    `CHK(pins_oe, 8'h00)
    `CHK(pins_o, 8'h00)
    `CHK(alert_n_oe, 1'h0)
    `CHK(alert_n_o, 1'h0)
    `CHK(sda_oe, 1'h0)
    `CHK(sda_o, 1'h0)
    rdr(`GXP_REG_DIR, 8'hff);
    rdr(`GXP_REG_OUTPUT, 8'h00);
    rdr(`GXP_REG_INVERT, 8'h00);
    rdr(`GXP_REG_INPUT, 8'h5a);
    $display("test reset defaults done");
  endtask

  task automatic t_dir();
    wr(`GXP_REG_OUTPUT, 8'ha5);
    wr(`GXP_REG_DIR, 8'h0f);
    `CHK(pins_oe, 8'hf0)
    `CHK(pins_o, 8'ha5)
    `CHK(alert_n_oe, 1'h0)
    rdr(`GXP_REG_DIR, 8'h0f);
    rdr(`GXP_REG_OUTPUT, 8'ha5);
    rdr(`GXP_REG_INPUT, 8'haa);
    $display("test direction and output done");
  endtask

  task automatic t_inv();
    wr(`GXP_REG_DIR, 8'hff);
    wr(`GXP_REG_INVERT, 8'h0f);
    `CHK(pins_oe, 8'h00)
    pin(8'h3c);
    rdr(`GXP_REG_INVERT, 8'h0f);
    rdr(`GXP_REG_INPUT, 8'h33);
    `CHK(alert_n_oe, 1'h0)
    $display("test polarity done");
  endtask

  task automatic t_alert();
    pin(8'h3d);
    `CHK(alert_n_oe, 1'h1)
    pin(8'h3c);
    `CHK(alert_n_oe, 1'h0)
    pin(8'h7c);
    `CHK(alert_n_oe, 1'h1)
    m.start();
    m.wbyte({`GXP_ADDR_BASE, ~addr_sel, 1'h0}, ack);
    `CHK(ack, 1'h0)
    m.stop();
    st(40);
    `CHK(alert_n_oe, 1'h1)
    rdr(`GXP_REG_INPUT, 8'h73);
    `CHK(alert_n_oe, 1'h0)
    $display("test change alert done");
  endtask

  // clock enable low freezes the alert, release lets it catch up
  task automatic t_ce();
    st(1);
    ce = 1'h0;
    pin(8'h7d);
    `CHK(alert_n_oe, 1'h0)
    st(1);
    ce = 1'h1;
    st(40);
    `CHK(alert_n_oe, 1'h1)
    pin(8'h7c);
    `CHK(alert_n_oe, 1'h0)
    $display("test clock enable done");
  endtask

  task automatic t_addr();
    st(1);
    addr_sel = 1'h1;
    st(40);
    wr(`GXP_REG_OUTPUT, 8'h3c);
    rdr(`GXP_REG_OUTPUT, 8'h3c);
    m.start();
    m.wbyte({`GXP_ADDR_BASE, 1'h0, 1'h1}, ack);
    `CHK(ack, 1'h0)
    m.stop();
    st(40);
    $display("test address select done");
  endtask

  task automatic t_rstpin();
    wr(`GXP_REG_DIR, 8'h00);
    `CHK(pins_oe, 8'hff)
    st(1);
    reset_pin_n = 1'h0;
    st(8);
    `CHK(pins_oe, 8'h00)
    reset_pin_n = 1'h1;
    st(40);
    `CHK(pins_o, 8'h00)
    rdr(`GXP_REG_DIR, 8'hff);
    rdr(`GXP_REG_OUTPUT, 8'h00);
    rdr(`GXP_REG_INVERT, 8'h00);
    $display("test reset pin done");
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard on core clock cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      summarize();
    end
  end

  // main sequence
  initial begin
    st(2);
    rst = 1'h0;
    st(40);
    t_reset();
    t_dir();
    t_inv();
    t_alert();
    t_ce();
    t_addr();
    t_rstpin();
    summarize();
  end
endmodule
